// >>> hdl/can_rx_mask_and_msg_buffer.sv
// Receive identifier mask filter and message buffer store with APB access
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps

module can_rx_mask_and_msg_buffer
    import can_filt_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic [11:0]          paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 bit_tick,
    input  wire logic                 rx_valid,
    input  wire can_filt_pkg::frame_t rx_frame,
    input  wire logic                 tx_done,
    input  wire logic [1:0]           tx_done_idx,
    input  wire logic [1:0]           tx_rd_idx,
    output logic [2:0]                tx_pending,
    output can_filt_pkg::frame_t      tx_frame,
    output logic [7:0]                tx_prio
);
    import can_filt_pkg::*;

    state_t q;
    state_t d;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic [7:0]        idx;
    logic              mapped;
    logic              is_filt;
    logic              is_buf;
    logic [1:0]        bsel;
    logic [1:0]        tsel;
    logic [3:0]        boff;
    logic [2:0]        fbyte;
    logic [NUM_TX-1:0] tx_empty;
    logic              tx_ok;
    logic              rd_ok;
    logic              wr_ok;
    logic              in_init;
    logic              acc;
    logic              commit;
    logic              wr_go;
    logic [7:0]        rdata;

    assign idx      = paddr[9:2];
    assign is_filt  = (idx[7:4] == IDX_FILT_HI);
    assign is_buf   = (idx >= IDX_BUF_BASE) && (idx <= IDX_BUF_END);
    assign mapped   = (paddr[11:10] == 2'h0)
                    && (idx == IDX_CTRL || idx == IDX_STAT || idx == IDX_SEL
                        || is_filt || is_buf);
    assign bsel     = 2'(idx[6:4] - BUF_GROUP0);
    assign tsel     = 2'(bsel - 2'h1);
    assign boff     = idx[3:0];
    // Code bytes and mask bytes interleave in two banks of four
    assign fbyte    = {idx[3], idx[1:0]};
    assign tx_empty = ~q.tx_pend;
    assign tx_ok    = (bsel != 2'h0) && tx_empty[tsel] && q.sel[tsel];
    assign rd_ok    = (bsel == 2'h0) ? (q.rx_full && boff != OFF_PRIO)
                                     : tx_ok;
    // Stamp bytes are never writable from the bus
    assign wr_ok    = tx_ok && (boff < OFF_STAMP_HI);
    assign in_init  = q.init_req && q.init_ack;
    assign acc      = psel && penable;
    assign commit   = acc && q.pready;
    assign wr_go    = commit && pwrite && mapped && pstrb[0];

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    always_comb
    begin
        rdata = 8'h00;
        if (idx == IDX_CTRL)
        begin
            rdata[CTRL_INIT_BIT]  = q.init_req;
            rdata[CTRL_STAMP_BIT] = q.stamp_en;
            rdata[CTRL_LAYOUT_LSB +: 2] = q.layout;
        end
        else if (idx == IDX_STAT)
        begin
            rdata[STAT_ACK_BIT] = q.init_ack;
            rdata[STAT_RXF_BIT] = q.rx_full;
            rdata[STAT_TXE_LSB +: NUM_TX] = tx_empty;
        end
        else if (idx == IDX_SEL)
        begin
            rdata[NUM_TX-1:0] = q.sel;
        end
        else if (is_filt)
        begin
            rdata = idx[2] ? q.mask[fbyte] : q.code[fbyte];
        end
        else if (is_buf && rd_ok)
        begin
            rdata = q.bufm[bsel][boff];
            // Upper half of the length byte is unused; it reads as zero
            if (boff == OFF_LEN)
            begin
                rdata[7:4] = 4'h0;
            end
        end
        if (paddr[11:10] != 2'h0)
        begin
            rdata = 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Acceptance filter
    // ------------------------------------------------------------------
    logic [MASK_BYTES-1:0] byte_ok;
    logic                  hit;
    logic                  rx_take;

    for (genvar n = 0; n < MASK_BYTES; n++)
    begin : g_cmp
        logic [7:0] id_sel;
        always_comb
        begin
            case (q.layout)
                LAYOUT_32: id_sel = rx_frame.ident[n % 4];
                LAYOUT_16: id_sel = rx_frame.ident[n % 2];
                default:   id_sel = rx_frame.ident[0];
            endcase
        end
        // Equality per bit, then forced true where the mask is set
        assign byte_ok[n] = &(~(id_sel ^ q.code[n]) | q.mask[n]);
    end

    always_comb
    begin
        case (q.layout)
            LAYOUT_32: hit = (&byte_ok[3:0]) || (&byte_ok[7:4]);
            LAYOUT_16: hit = (&byte_ok[1:0]) || (&byte_ok[3:2])
                          || (&byte_ok[5:4]) || (&byte_ok[7:6]);
            LAYOUT_8:  hit = |byte_ok;
            default:   hit = 1'b0;
        endcase
    end

    // A frame arriving while the buffer is still full is dropped
    assign rx_take = rx_valid && hit && !in_init && !q.rx_full;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        d          = q;
        d.init_ack = q.init_req;
        d.pready   = acc && !q.pready;
        if (acc && !q.pready)
        begin
            d.prdata  = {24'h0, rdata};
            d.pslverr = !mapped;
        end
        if (in_init)
        begin
            d.timer = '0;
        end
        else if (bit_tick)
        begin
            d.timer = TIMER_W'(q.timer + 1'b1);
        end

        if (wr_go)
        begin
            if (idx == IDX_CTRL)
            begin
                d.init_req = pwdata[CTRL_INIT_BIT];
                if (in_init)
                begin
                    d.stamp_en = pwdata[CTRL_STAMP_BIT];
                    d.layout   = layout_t'(pwdata[CTRL_LAYOUT_LSB +: 2]);
                end
            end
            else if (idx == IDX_STAT)
            begin
                if (pwdata[STAT_RXF_BIT])
                begin
                    d.rx_full = 1'b0;
                end
                d.tx_pend = q.tx_pend | pwdata[STAT_TXE_LSB +: NUM_TX];
            end
            else if (idx == IDX_SEL)
            begin
                // Keep only the lowest set bit so one buffer is chosen
                d.sel = pwdata[NUM_TX-1:0] & (~pwdata[NUM_TX-1:0] + 3'h1);
            end
            else if (is_filt && in_init)
            begin
                if (idx[2])
                begin
                    d.mask[fbyte] = pwdata[7:0];
                end
                else
                begin
                    d.code[fbyte] = pwdata[7:0];
                end
            end
            else if (is_buf && wr_ok)
            begin
                d.bufm[bsel][boff] = pwdata[7:0];
                if (boff == OFF_LEN)
                begin
                    d.bufm[bsel][boff] = {4'h0, pwdata[3:0] & LEN_MASK};
                end
            end
        end

        // Hardware updates come last so they win over a same-cycle bus write
        if (rx_take)
        begin
            for (int i = 0; i < 4; i++)
            begin
                d.bufm[0][4'(OFF_IDENT + i)] = rx_frame.ident[i];
            end
            for (int i = 0; i < 8; i++)
            begin
                d.bufm[0][4'(OFF_DATA + i)] = rx_frame.payload[i];
            end
            d.bufm[0][OFF_LEN] = {4'h0, rx_frame.length};
            if (q.stamp_en)
            begin
                d.bufm[0][OFF_STAMP_HI] = q.timer[15:8];
                d.bufm[0][OFF_STAMP_LO] = q.timer[7:0];
            end
            d.rx_full = 1'b1;
        end
        if (tx_done && tx_done_idx < 2'(NUM_TX))
        begin
            d.tx_pend[tx_done_idx] = 1'b0;
            if (q.stamp_en)
            begin
                d.bufm[2'(tx_done_idx + 1'b1)][OFF_STAMP_HI] = q.timer[15:8];
                d.bufm[2'(tx_done_idx + 1'b1)][OFF_STAMP_LO] = q.timer[7:0];
            end
        end

        d.tx_frame.ident   = q.bufm[2'(tx_rd_idx + 1'b1)][3:0];
        d.tx_frame.payload = q.bufm[2'(tx_rd_idx + 1'b1)][11:4];
        d.tx_frame.length  = q.bufm[2'(tx_rd_idx + 1'b1)][OFF_LEN][3:0];
        d.tx_prio          = q.bufm[2'(tx_rd_idx + 1'b1)][OFF_PRIO];
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Buffer storage behaves as RAM; clearing it here is harmless and
    // also gives the transmit priority bytes their zero reset value.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= STATE_RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign prdata     = q.prdata;
    assign pready     = q.pready;
    assign pslverr    = q.pslverr;
    assign tx_pending = q.tx_pend;
    assign tx_frame   = q.tx_frame;
    assign tx_prio    = q.tx_prio;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [3:0][15:0] stamps;
    for (genvar b = 0; b < 4; b++)
    begin : g_stamp
        assign stamps[b] = {q.bufm[b][OFF_STAMP_HI], q.bufm[b][OFF_STAMP_LO]};
    end

    mask_lock_a: assert property (
        wr_go && is_filt && !in_init |=> $stable(q.mask) && $stable(q.code))
        else $error("filter bytes changed outside init");

    stamp_ro_a: assert property (
        !rx_take && !tx_done |=> $stable(stamps))
        else $error("stamp changed without a frame");

    accept_hit_a: assert property (
        rx_take |-> hit && !q.rx_full ##1 q.rx_full)
        else $error("frame taken without filter hit");

    closed_a: assert property (
        q.layout == LAYOUT_CLOSED |-> !hit)
        else $error("closed filter accepted a frame");

    dont_care_a: assert property (
        rx_valid && q.layout == LAYOUT_16 && rx_frame.ident[0] == q.code[0]
        && ((rx_frame.ident[1] ^ q.code[1]) & ~q.mask[1]) == 8'h00 |-> hit)
        else $error("masked bit difference rejected a frame");

    rx_ro_a: assert property (
        wr_go && is_buf && bsel == 2'h0 && !rx_take |=> $stable(q.bufm[0]))
        else $error("bus write altered receive buffer");

    tx_lock_a: assert property (
        wr_go && is_buf && !tx_ok && !rx_take && !tx_done |=> $stable(q.bufm))
        else $error("refused buffer write took effect");

    rx_gate_a: assert property (
        acc && !q.pready && is_buf && bsel == 2'h0 && !q.rx_full
        |=> prdata == 32'h0 ##1 !pready)
        else $error("empty receive buffer returned data");

    stamp_val_a: assert property (
        rx_take && q.stamp_en |=> stamps[0] == $past(q.timer))
        else $error("receive stamp differs from timer");

    stamp_tx_a: assert property (
        tx_done && tx_done_idx == 2'h1 && q.stamp_en |=> stamps[2] == $past(q.timer))
        else $error("transmit stamp differs from timer");

    apb_wait_a: assert property (
        psel && !penable |=> !pready ##1 (pready || !penable))
        else $error("bus answer timing broken");

    rx_take_c: cover property (rx_take ##[1:20] wr_go && idx == IDX_STAT);
    tx_write_c: cover property (wr_go && is_buf && wr_ok);
    tx_stamp_c: cover property (tx_done && q.stamp_en);
    init_mask_c: cover property (wr_go && is_filt && in_init);

endmodule

// >>> hdl/can_filt_pkg.sv
// Constants, types and register map of the receive mask stage and message buffers
package can_filt_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL     = 8'h00;
    localparam logic [7:0] IDX_STAT     = 8'h01;
    localparam logic [7:0] IDX_SEL      = 8'h02;
    localparam logic [7:0] IDX_CODE_LO  = 8'h10;
    localparam logic [7:0] IDX_MASK0    = 8'h14;
    localparam logic [7:0] IDX_MASK1    = 8'h15;
    localparam logic [7:0] IDX_MASK2    = 8'h16;
    localparam logic [7:0] IDX_MASK3    = 8'h17;
    localparam logic [7:0] IDX_CODE_HI  = 8'h18;
    localparam logic [7:0] IDX_MASK_HI  = 8'h1c;
    localparam logic [3:0] IDX_FILT_HI  = 4'h1;
    localparam logic [7:0] IDX_BUF_BASE = 8'h20;
    localparam logic [7:0] IDX_BUF_END  = 8'h5f;
    localparam logic [2:0] BUF_GROUP0   = 3'h2;

    // ------------------------------------------------------------------
    // Offsets inside one 16-byte buffer window
    // ------------------------------------------------------------------
    localparam logic [3:0] OFF_IDENT    = 4'h0;
    localparam logic [3:0] OFF_DATA     = 4'h4;
    localparam logic [3:0] OFF_LEN      = 4'hc;
    localparam logic [3:0] OFF_PRIO     = 4'hd;
    localparam logic [3:0] OFF_STAMP_HI = 4'he;
    localparam logic [3:0] OFF_STAMP_LO = 4'hf;

    // ------------------------------------------------------------------
    // Control and status bit positions
    // ------------------------------------------------------------------
    localparam int CTRL_INIT_BIT   = 0;
    localparam int CTRL_STAMP_BIT  = 1;
    localparam int CTRL_LAYOUT_LSB = 2;
    localparam int STAT_ACK_BIT    = 0;
    localparam int STAT_RXF_BIT    = 1;
    localparam int STAT_TXE_LSB    = 2;

    localparam int NUM_TX     = 3;
    localparam int MASK_BYTES = 8;
    localparam int TIMER_W    = 16;
    localparam logic [3:0] LEN_MASK = 4'hf;

    typedef enum logic [1:0] {
        LAYOUT_32     = 2'b00,
        LAYOUT_16     = 2'b01,
        LAYOUT_8      = 2'b10,
        LAYOUT_CLOSED = 2'b11
    } layout_t;

    typedef struct packed {
        logic [3:0][7:0] ident;
        logic [7:0][7:0] payload;
        logic [3:0]      length;
    } frame_t;

    typedef struct packed {
        logic                      init_req;
        logic                      init_ack;
        logic                      stamp_en;
        layout_t                   layout;
        logic                      rx_full;
        logic [NUM_TX-1:0]         tx_pend;
        logic [NUM_TX-1:0]         sel;
        logic [TIMER_W-1:0]        timer;
        logic [MASK_BYTES-1:0][7:0] mask;
        logic [MASK_BYTES-1:0][7:0] code;
        logic [3:0][15:0][7:0]     bufm;
        logic [31:0]               prdata;
        logic                      pready;
        logic                      pslverr;
        frame_t                    tx_frame;
        logic [7:0]                tx_prio;
    } state_t;

    localparam state_t STATE_RST = '0;

endpackage

// >>> sim/can_side_model.sv
// Behavioural CAN-side partner: received frames, transmit completions, bit ticks
`timescale 1ns/100ps

module can_side_model
    import can_filt_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    output logic               bit_tick,
    output logic               rx_valid,
    output can_filt_pkg::frame_t rx_frame,
    output logic               tx_done,
    output logic [1:0]         tx_done_idx
);
    logic [2:0] tick_q;

    initial
    begin
        rx_valid    = 1'b0;
        rx_frame    = '0;
        tx_done     = 1'b0;
        tx_done_idx = 2'h0;
    end

    // Bit clock runs free, one tick every eight cycles
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            tick_q <= 3'h0;
        else
            tick_q <= tick_q + 3'h1;
    assign bit_tick = (tick_q == 3'h7);

    // Frame lines carry the inverse of the last frame while not valid
    task automatic send_frame(input frame_t f);
        @(posedge pclk);
        rx_valid <= 1'b1;
        rx_frame <= f;
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_frame <= ~f;
    endtask

    task automatic finish_tx(input logic [1:0] idx);
        @(posedge pclk);
        tx_done     <= 1'b1;
        tx_done_idx <= idx;
        @(posedge pclk);
        tx_done     <= 1'b0;
        tx_done_idx <= ~idx;
    endtask
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the mask filter and message buffer block
`timescale 1ns/100ps

module tb_top;
    import can_filt_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        bit_tick, rx_valid, tx_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [1:0]  tx_done_idx, tx_rd_idx;
    logic [2:0]  tx_pending;
    logic [3:0]  pstrb;
    logic [7:0]  tx_prio;
    logic        e;
    frame_t      rx_frame, tx_frame;
    int          error_cnt, total_checks, cyc;

    can_rx_mask_and_msg_buffer can_rx_mask_and_msg_buffer_i (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bit_tick(bit_tick), .rx_valid(rx_valid), .rx_frame(rx_frame),
        .tx_done(tx_done), .tx_done_idx(tx_done_idx), .tx_rd_idx(tx_rd_idx),
        .tx_pending(tx_pending), .tx_frame(tx_frame), .tx_prio(tx_prio));

    can_side_model can_side_model_i (
        .pclk(pclk), .presetn(presetn), .bit_tick(bit_tick), .rx_valid(rx_valid),
        .rx_frame(rx_frame), .tx_done(tx_done), .tx_done_idx(tx_done_idx));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Completion is judged on pready itself; no fixed wait-state count is assumed
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // Sampled at the rising edge; only the bench timeout ends this wait
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        chk(r, {24'h000000, x});
    endtask

    task automatic init_mode(input logic [1:0] lay, input logic on);
        apb(1'b1, 12'h000, 8'h01);
        apb(1'b1, 12'h000, {4'h0, lay, 2'b11});
        if (!on)
            apb(1'b1, 12'h000, {4'h0, lay, 2'b10});
    endtask

    function automatic frame_t mk(input logic [31:0] id, input logic [3:0] len);
        frame_t f;
        f.ident   = {id[7:0], id[15:8], id[23:16], id[31:24]};
        f.payload = 64'h8877665544332211 ^ {8{id[7:0]}};
        f.length  = len;
        return f;
    endfunction

    // Frame must be taken or dropped as the filter says; a taken one is read back whole
    task automatic rx_case(input logic [31:0] id, input logic [3:0] len, input logic hit,
                           input logic keep);
        frame_t f;
        f = mk(id, len);
        can_side_model_i.send_frame(f);
        apb(1'b0, 12'h004, 8'h00);
        chk({31'h0, r[1]}, {31'h0, hit});
        if (hit)
            for (int o = 0; o < 13; o++)
                rd(12'h080 + 12'(4 * o), o < 4 ? f.ident[o] : o < 12 ? f.payload[o - 4]
                   : {4'h0, f.length});
        if (!keep)
            apb(1'b1, 12'h004, 8'h02);
    endtask

    task automatic t_masks();
        logic [7:0] m [4];
        m = '{8'h00, 8'h07, 8'h00, 8'h00};
        for (int i = 0; i < 4; i++)
            rd(12'h050 + 12'(4 * i), 8'h00);
        apb(1'b1, 12'h054, 8'hff);
        rd(12'h054, 8'h00);
        init_mode(2'b00, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, 12'h040 + 12'(4 * i), 8'(32'ha53c127e >> (24 - 8 * i)));
            apb(1'b1, 12'h050 + 12'(4 * i), m[i]);
        end
        rd(12'h054, 8'h07);
        init_mode(2'b00, 1'b0);
        $display("test masks done");
    endtask

    task automatic t_filter();
        rx_case(32'ha53c127e, 4'h8, 1'b1, 1'b0);
        rx_case(32'ha539127e, 4'h0, 1'b1, 1'b0);
        rx_case(32'ha53c137e, 4'h3, 1'b0, 1'b0);
        rx_case(32'ha53c127f, 4'h5, 1'b0, 1'b0);
        $display("test filter done");
    endtask

    task automatic t_rx_access();
        logic [31:0] s;
        rd(12'h080, 8'h00);
        rx_case(32'ha53c127e, 4'h2, 1'b1, 1'b1);
        rd(12'h0b4, 8'h00);
        apb(1'b1, 12'h080, 8'hee);
        rd(12'h080, 8'ha5);
        apb(1'b0, 12'h0b8, 8'h00);
        s = r;
        apb(1'b1, 12'h0b8, 8'h5c);
        rd(12'h0b8, s[7:0]);
        apb(1'b1, 12'h004, 8'h02);
        $display("test rx access done");
    endtask

    task automatic t_tx();
        apb(1'b1, 12'h008, 8'h06);
        rd(12'h008, 8'h02);
        rd(12'h134, 8'h00);
        apb(1'b1, 12'h100, 8'h5a);
        apb(1'b1, 12'h134, 8'h03);
        apb(1'b1, 12'h130, 8'hf5);
        rd(12'h130, 8'h05);
        rd(12'h100, 8'h5a);
        // A write without its low byte strobe must leave the buffer alone
        pstrb <= 4'he;
        apb(1'b1, 12'h100, 8'h33);
        pstrb <= 4'hf;
        rd(12'h100, 8'h5a);
        tx_rd_idx <= 2'h1;
        repeat (3) @(posedge pclk);
        chk({24'h0, tx_frame.ident[0]}, 32'h5a);
        chk({24'h0, tx_prio}, 32'h03);
        chk({28'h0, tx_frame.length}, 32'h5);
        apb(1'b1, 12'h004, 8'h08);
        @(posedge pclk);
        chk({29'h0, tx_pending}, 32'h2);
        rd(12'h100, 8'h00);
        apb(1'b1, 12'h100, 8'h77);
        can_side_model_i.finish_tx(2'h1);
        @(posedge pclk);
        chk({29'h0, tx_pending}, 32'h0);
        rd(12'h100, 8'h5a);
        $display("test tx done");
    endtask

    task automatic t_layouts();
        logic [3:0] hit;
        hit = 4'b0110;
        init_mode(2'b01, 1'b1);
        apb(1'b1, 12'h05c, 8'h07);
        apb(1'b1, 12'h074, 8'h07);
        apb(1'b1, 12'h07c, 8'h07);
        rd(12'h07c, 8'h07);
        for (int l = 0; l < 4; l++)
        begin
            init_mode(2'(l), 1'b0);
            // Byte 1 differs only in masked bits, so the 16-bit filter must hit
            rx_case(32'ha5395555, 4'h1, hit[l], 1'b0);
        end
        apb(1'b1, 12'h3fc, 8'h11);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 12'h3fc, 8'h00);
        chk({r[31:1], e}, 32'h1);
        $display("test layouts and unmapped done");
    endtask

    initial
    begin
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h00000000;
        tx_rd_idx = 2'h0;
        pstrb     = 4'hf;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_masks();
        t_filter();
        t_rx_access();
        t_tx();
        t_layouts();
        finish_test();
    end
endmodule
